// *** rtl/ddrio_cfg.svh ***
`ifndef DDRIO_CFG_SVH
`define DDRIO_CFG_SVH
// Delay line tap for the fixed input delay; tap n lags the undelayed input by n+1 system clock cycles.
`define DDRIO_FIXED_DLY 4'h3
// Depth of the input delay line; the dynamic selector spans all of it.
`define DDRIO_DLY_DEPTH 16
// Reset value of data-carrying registers.
`define DDRIO_RST_DATA 1'b0
// Reset value of the tristate registers: the pad is released.
`define DDRIO_RST_TS 1'b1
// Last position of the four-bit output serialiser.
`define DDRIO_SER_LAST 2'h3
`endif

// *** rtl/ddrio_pkg.sv ***
package ddrio_pkg;
  // Which edge of the die the cell sits on; this limits the modes it offers.
  typedef enum logic [3:0] {
    DDRIO_LEFT = 4'h1,
    DDRIO_RIGHT = 4'h2,
    DDRIO_TOP = 4'h4,
    DDRIO_BOTTOM = 4'h8
  } ddrio_side_t;
  // Data rate of the input or output path.
  typedef enum logic [2:0] {
    DDRIO_SDR = 3'h1,
    DDRIO_DDR = 3'h2,
    DDRIO_GEAR = 3'h4
  } ddrio_rate_t;
  // Input delay choice.
  typedef enum logic [2:0] {
    DDRIO_DLY_NONE = 3'h1,
    DDRIO_DLY_FIXED = 3'h2,
    DDRIO_DLY_DYN = 3'h4
  } ddrio_dly_t;
  typedef struct packed {
    ddrio_rate_t in_mode;
    ddrio_dly_t dly_mode;
    logic memory_mode;
    logic edge_clock_sel;
  } ddrio_in_cfg_t;
  typedef struct packed {
    ddrio_rate_t out_mode;
    logic sdr_latch;
    logic isi_en;
  } ddrio_out_cfg_t;
  typedef struct packed {
    logic out_fall_b;
    logic out_rise_b;
    logic out_fall_a;
    logic out_rise_a;
  } ddrio_core_out_t;
  typedef struct packed {
    logic gear_in_neg_b;
    logic gear_in_pos_b;
    logic gear_in_neg_a;
    logic gear_in_pos_a;
  } ddrio_gear_in_t;
endpackage

// *** rtl/ddrio_gear.sv ***
`timescale 1ns/10ps
`include "ddrio_cfg.svh"
// What this block does
// - Bottom edge: single input capture register only.
// - Pad signal may bypass the delay line and capture registers.
// - Input delay fixed or four-bit dynamic select.
// - Single rate input: one system clock register.
// - Double rate: capture on rising and falling edges.
// - Both captured streams resynchronised to system clock.
// - Input gearbox, left/right only: four core streams.
// - Read polarity picks synchronising register capture edge.
// - Read latch enable gates transfer to gearbox.
// - Single rate output: flip-flop or latch element.
// - Double rate output: register two, latch one.
// - Double rate pad mux alternates both paths.
// - Output gearbox registers four, latches two streams.
// - Quadrature write clocks serialise four streams out.
// - Top: no output gearbox; bottom: single rate.
// - Tristate control registered once in non-gearbox modes.
// - Gearbox: tristate reregistered on write clocks.
// - Interference correction only in gearbox modes.
// - Separate interference setting for each output block.
// - Lone one or lone zero gets stretched.
// - Long run transitions get no stretching.
// - Stretch amount from three-bit delay control.
// - Core clock enable gates cell data registers.
// - Valid flag raised when captured data ready.
module ddrio_gear #(
  parameter ddrio_pkg::ddrio_side_t SIDE = ddrio_pkg::DDRIO_LEFT
) (
  input wire logic CLK,
  input wire logic RESETN,
  input wire logic PAD_INPUT_SIGNAL,
  output logic PAD_OUT,
  output logic PAD_OE,
  output logic BYPASS_COMB_INPUT,
  output logic BYPASS_CLOCK_INPUT,
  input wire ddrio_pkg::ddrio_in_cfg_t IN_CFG,
  input wire ddrio_pkg::ddrio_out_cfg_t OUT_CFG,
  input wire logic [3:0] DYNAMIC_INPUT_DELAY_SEL,
  input wire logic [2:0] ISI_DELAY_CTRL,
  input wire logic DELAYED_STROBE_CAPTURE_CLOCK,
  input wire logic EDGE_CLOCK_ONE,
  input wire logic EDGE_CLOCK_TWO,
  input wire logic READ_SYNC_POLARITY,
  input wire logic READ_TRANSFER_LATCH_ENABLE,
  input wire logic WRITE_QUAD_CLOCK_ZERO,
  input wire logic WRITE_QUAD_CLOCK_ONE,
  input wire logic CORE_CLOCK_ENABLE,
  input wire logic LOCAL_SET_RESET,
  input wire logic GLOBAL_SET_RESET_N,
  input wire ddrio_pkg::ddrio_core_out_t OUT_DATA,
  input wire logic TRISTATE_CONTROL,
  output ddrio_pkg::ddrio_gear_in_t IN_DATA,
  output logic CAPTURE_VALID_FLAG
);
  logic [5:0] s1_ff, s2_ff, s3_ff;
  logic [`DDRIO_DLY_DEPTH-1:0] dly_ff;
  logic d_in, lrst, ce, cap_r, cap_f, cap_f_d_ff, sync_ld, ld_ff, xfer, wclk_ev;
  logic pos_ff, neg_ff, sp_ff, sn_ff, hold_p_ff, hold_n_ff, valid_ff;
  ddrio_pkg::ddrio_gear_in_t in_q_ff;
  ddrio_pkg::ddrio_rate_t im, om;
  ddrio_pkg::ddrio_core_out_t g_ff;
  logic ph_ff, fa_lat_ff, pad_ff, nxt_pad, oe_ff, ts_ff, ts2_ff, nb, lone, isi_on;
  logic [1:0] gl_ff, idx_ff, h_ff;
  logic [3:0] ser_ff;
  logic [2:0] isi_cnt_ff;

  // The pad input and every foreign clock pass two flip-flops; a third copy finds edges.
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      s1_ff <= 6'h00;
      s2_ff <= 6'h00;
      s3_ff <= 6'h00;
    end else begin
      s1_ff <= {WRITE_QUAD_CLOCK_ONE, WRITE_QUAD_CLOCK_ZERO, EDGE_CLOCK_TWO,
                EDGE_CLOCK_ONE, DELAYED_STROBE_CAPTURE_CLOCK, PAD_INPUT_SIGNAL};
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
    end
  end

  // Either reset source clears the cell; the core enable gates data loads.
  assign lrst = LOCAL_SET_RESET | ~GLOBAL_SET_RESET_N;
  assign ce = CORE_CLOCK_ENABLE;
  // The write clocks move data on each of their edges, four per period.
  assign wclk_ev = |(s2_ff[5:4] ^ s3_ff[5:4]);

  // Bypass paths skip the delay line and every capture register.
  assign BYPASS_COMB_INPUT = s2_ff[0];
  assign BYPASS_CLOCK_INPUT = s2_ff[0];

  // Cell edge limits the modes: bottom is single rate, top has no out gearbox.
  always_comb begin
    im = IN_CFG.in_mode;
    om = OUT_CFG.out_mode;
    if (SIDE == ddrio_pkg::DDRIO_BOTTOM) begin
      im = ddrio_pkg::DDRIO_SDR;
      om = ddrio_pkg::DDRIO_SDR;
    end else if (SIDE == ddrio_pkg::DDRIO_TOP) begin
      if (im == ddrio_pkg::DDRIO_GEAR) begin
        im = ddrio_pkg::DDRIO_DDR;
      end
      if (om == ddrio_pkg::DDRIO_GEAR) begin
        om = ddrio_pkg::DDRIO_DDR;
      end
    end
  end

  // Delay line of the synchronised pad; one tap per system clock cycle.
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      dly_ff <= '0;
    end else begin
      dly_ff <= {dly_ff[`DDRIO_DLY_DEPTH-2:0], s2_ff[0]};
    end
  end

  // Fixed tap or core-selected tap, or no delay at all.
  always_comb begin
    if (IN_CFG.dly_mode == ddrio_pkg::DDRIO_DLY_FIXED) begin
      d_in = dly_ff[`DDRIO_FIXED_DLY];
    end else if (IN_CFG.dly_mode == ddrio_pkg::DDRIO_DLY_DYN) begin
      d_in = dly_ff[DYNAMIC_INPUT_DELAY_SEL];
    end else begin
      d_in = s2_ff[0];
    end
  end

  // Capture clock is the delayed strobe for memory, else the chosen edge clock.
  always_comb begin
    if (IN_CFG.memory_mode) begin
      cap_r = s2_ff[1] & ~s3_ff[1];
      cap_f = ~s2_ff[1] & s3_ff[1];
    end else if (IN_CFG.edge_clock_sel) begin
      cap_r = s2_ff[3] & ~s3_ff[3];
      cap_f = ~s2_ff[3] & s3_ff[3];
    end else begin
      cap_r = s2_ff[2] & ~s3_ff[2];
      cap_f = ~s2_ff[2] & s3_ff[2];
    end
  end

  // Sync registers load on the capture rise, or just after the capture fall.
  assign sync_ld = READ_SYNC_POLARITY ? cap_r : cap_f_d_ff;
  assign xfer = ld_ff & READ_TRANSFER_LATCH_ENABLE & ce;

  // Double rate capture, resynchronisation and gearbox holding stage.
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      {pos_ff, neg_ff, sp_ff, sn_ff} <= 4'h0;
      {hold_p_ff, hold_n_ff, cap_f_d_ff, ld_ff} <= 4'h0;
    end else if (lrst) begin
      {pos_ff, neg_ff, sp_ff, sn_ff} <= 4'h0;
      {hold_p_ff, hold_n_ff, cap_f_d_ff, ld_ff} <= 4'h0;
    end else begin
      cap_f_d_ff <= cap_f;
      ld_ff <= sync_ld & ce & (im != ddrio_pkg::DDRIO_SDR);
      if (ce && im != ddrio_pkg::DDRIO_SDR) begin
        if (cap_r) begin
          pos_ff <= d_in;
        end
        if (cap_f) begin
          neg_ff <= d_in;
        end
        if (sync_ld) begin
          sp_ff <= pos_ff;
          sn_ff <= neg_ff;
          hold_p_ff <= sp_ff;
          hold_n_ff <= sn_ff;
        end
      end
    end
  end

  // Core-facing input register; in single rate it is the only capture stage.
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      in_q_ff <= 4'h0;
      valid_ff <= 1'b0;
    end else if (lrst) begin
      in_q_ff <= 4'h0;
      valid_ff <= 1'b0;
    end else if (im == ddrio_pkg::DDRIO_SDR) begin
      valid_ff <= ce;
      if (ce) begin
        in_q_ff <= {3'h0, d_in};
      end
    end else begin
      valid_ff <= xfer;
      if (xfer && im == ddrio_pkg::DDRIO_GEAR) begin
        in_q_ff <= {sn_ff, sp_ff, hold_n_ff, hold_p_ff};
      end else if (xfer) begin
        in_q_ff <= {2'h0, sn_ff, sp_ff};
      end
    end
  end
  assign IN_DATA = in_q_ff;
  assign CAPTURE_VALID_FLAG = valid_ff;

  // Core output registers; in double rate a word is taken every other cycle.
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      g_ff <= 4'h0;
      gl_ff <= 2'h0;
      fa_lat_ff <= `DDRIO_RST_DATA;
      ph_ff <= 1'b0;
    end else if (lrst) begin
      g_ff <= 4'h0;
      gl_ff <= 2'h0;
      fa_lat_ff <= `DDRIO_RST_DATA;
      ph_ff <= 1'b0;
    end else begin
      ph_ff <= (om == ddrio_pkg::DDRIO_DDR) ? ~ph_ff : 1'b0;
      if (ce && (om != ddrio_pkg::DDRIO_DDR || !ph_ff)) begin
        g_ff <= OUT_DATA;
      end
      fa_lat_ff <= g_ff.out_fall_a;
      gl_ff <= {g_ff.out_fall_b, g_ff.out_rise_b};
    end
  end

  // Next serial bit at a write clock edge; a new word enters after the last bit.
  assign nb = (idx_ff == `DDRIO_SER_LAST) ? g_ff.out_rise_a : ser_ff[idx_ff + 2'h1];
  assign lone = (h_ff[1] != h_ff[0]) && (nb != h_ff[0]);
  assign isi_on = (om == ddrio_pkg::DDRIO_GEAR) && OUT_CFG.isi_en;

  // Four-to-one serialiser stepped by the quadrature write clocks.
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      ser_ff <= 4'h0;
      idx_ff <= `DDRIO_SER_LAST;
      h_ff <= 2'h0;
    end else if (lrst) begin
      ser_ff <= 4'h0;
      idx_ff <= `DDRIO_SER_LAST;
      h_ff <= 2'h0;
    end else if (wclk_ev && om == ddrio_pkg::DDRIO_GEAR) begin
      idx_ff <= idx_ff + 2'h1;
      h_ff <= {h_ff[0], nb};
      if (idx_ff == `DDRIO_SER_LAST) begin
        ser_ff <= {gl_ff, g_ff.out_fall_a, g_ff.out_rise_a};
      end
    end
  end

  // A lone bit keeps the pad for extra cycles before the next transition.
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      isi_cnt_ff <= 3'h0;
    end else if (lrst || !isi_on) begin
      isi_cnt_ff <= 3'h0;
    end else if (wclk_ev && lone && ISI_DELAY_CTRL != 3'h0) begin
      isi_cnt_ff <= ISI_DELAY_CTRL;
    end else if (isi_cnt_ff != 3'h0) begin
      isi_cnt_ff <= isi_cnt_ff - 3'h1;
    end
  end

  // Pad data selection per output mode.
  always_comb begin
    nxt_pad = pad_ff;
    if (om == ddrio_pkg::DDRIO_GEAR) begin
      nxt_pad = (isi_cnt_ff != 3'h0) ? h_ff[1] : h_ff[0];
    end else if (om == ddrio_pkg::DDRIO_DDR) begin
      nxt_pad = ph_ff ? g_ff.out_rise_a : fa_lat_ff;
    end else if (!OUT_CFG.sdr_latch) begin
      nxt_pad = g_ff.out_rise_a;
    end else if (ce) begin
      nxt_pad = OUT_DATA.out_rise_a;
    end
  end

  // Pad register and the tristate path.
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      pad_ff <= `DDRIO_RST_DATA;
      ts_ff <= `DDRIO_RST_TS;
      ts2_ff <= `DDRIO_RST_TS;
      oe_ff <= 1'b0;
    end else if (lrst) begin
      pad_ff <= `DDRIO_RST_DATA;
      ts_ff <= `DDRIO_RST_TS;
      ts2_ff <= `DDRIO_RST_TS;
      oe_ff <= 1'b0;
    end else begin
      pad_ff <= nxt_pad;
      if (ce) begin
        ts_ff <= TRISTATE_CONTROL;
      end
      if (wclk_ev) begin
        ts2_ff <= ts_ff;
      end
      oe_ff <= (om == ddrio_pkg::DDRIO_GEAR) ? ~ts2_ff : ~ts_ff;
    end
  end
  assign PAD_OUT = pad_ff;
  assign PAD_OE = oe_ff;

  // Checks on the cell behaviour.
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESETN);
  a_bottom_modes: assert property (SIDE == ddrio_pkg::DDRIO_BOTTOM |->
    im == ddrio_pkg::DDRIO_SDR && om == ddrio_pkg::DDRIO_SDR)
    else $error("Bottom cell left single rate.");
  a_bypass_path: assert property (RESETN && $past(RESETN, 3) |->
    BYPASS_COMB_INPUT == $past(PAD_INPUT_SIGNAL, 2))
    else $error("Bypass does not follow the pad.");
  a_dyn_delay_tap: assert property (IN_CFG.dly_mode == ddrio_pkg::DDRIO_DLY_DYN &&
    DYNAMIC_INPUT_DELAY_SEL == 4'h0 && $past(RESETN) |-> d_in == $past(s2_ff[0]))
    else $error("Dynamic delay tap wrong.");
  a_sdr_capture: assert property (im == ddrio_pkg::DDRIO_SDR && ce && !lrst |=>
    IN_DATA.gear_in_pos_a == $past(d_in))
    else $error("Single rate capture missed.");
  a_ddr_rise_cap: assert property (im != ddrio_pkg::DDRIO_SDR && ce && cap_r &&
    !lrst |=> pos_ff == $past(d_in))
    else $error("Rising capture missed.");
  a_sync_polarity: assert property (READ_SYNC_POLARITY && cap_r && ce && !lrst &&
    im != ddrio_pkg::DDRIO_SDR |=> sp_ff == $past(pos_ff))
    else $error("Sync register ignored polarity.");
  a_xfer_gated: assert property (!READ_TRANSFER_LATCH_ENABLE && !lrst &&
    im != ddrio_pkg::DDRIO_SDR |=> $stable(IN_DATA) && !CAPTURE_VALID_FLAG)
    else $error("Transfer without latch enable.");
  a_valid_flag: assert property (xfer && !lrst && im != ddrio_pkg::DDRIO_SDR |=>
    CAPTURE_VALID_FLAG)
    else $error("Valid flag not raised.");
  a_ddr_pad_mux: assert property (om == ddrio_pkg::DDRIO_DDR && ph_ff && !lrst |=>
    PAD_OUT == $past(g_ff.out_rise_a))
    else $error("Double rate mux wrong.");
  a_ts_single: assert property (om != ddrio_pkg::DDRIO_GEAR && ts_ff && !lrst |=>
    !PAD_OE)
    else $error("Pad driven while tristated.");
  a_isi_only_gear: assert property (om != ddrio_pkg::DDRIO_GEAR |=>
    isi_cnt_ff == 3'h0)
    else $error("Stretch outside gearbox mode.");
  a_isi_amount: assert property (isi_on && wclk_ev && lone && !lrst |=>
    isi_cnt_ff == $past(ISI_DELAY_CTRL))
    else $error("Stretch amount wrong.");
  a_set_reset: assert property (lrst |=> !PAD_OE && !CAPTURE_VALID_FLAG &&
    IN_DATA == 4'h0)
    else $error("Set/reset did not clear cell.");
  c_gear_xfer: cover property (im == ddrio_pkg::DDRIO_GEAR && xfer);
  c_isi_stretch: cover property (isi_cnt_ff != 3'h0);
  c_ddr_out: cover property (om == ddrio_pkg::DDRIO_DDR && ph_ff ##1 !ph_ff);
endmodule

// *** bench/ddrio_src.sv ***
`timescale 1ns/10ps
module ddrio_src (
  input wire logic go,
  input wire logic [1:0] bits,
  output logic cap_clk,
  output logic dq
);
  // Each rise of go sends a burst of six strobe periods of 400 ns; the strobe rests low between bursts.
  initial begin
    cap_clk = 1'b0;
    dq = 1'b0;
    forever begin
      @(posedge go);
      repeat (6) begin
        dq = bits[1]; // Rising-edge bit, set up a quarter period early.
        #100 cap_clk = 1'b1;
        #100 dq = bits[0]; // Falling-edge bit.
        #100 cap_clk = 1'b0;
        #100;
      end
      dq = ~bits[0]; // A released line shows the inverse of the last bit.
    end
  end
endmodule

// *** bench/test_ddrio_gear.sv ***
`timescale 1ns/10ps
module test_ddrio_gear;
  logic clk, resetn, pad_drv, pad_out, pad_oe, byp_c, byp_k, pol, lat, ce, local_set_reset, gsr_n, ts;
  logic go, cap_clk, dq, valid, qrun, use_src;
  logic [2:0] qc;
  logic [3:0] dsel;
  logic [2:0] isi;
  logic [1:0] bits;
  ddrio_pkg::ddrio_in_cfg_t in_cfg;
  ddrio_pkg::ddrio_out_cfg_t out_cfg;
  ddrio_pkg::ddrio_core_out_t od;
  ddrio_pkg::ddrio_gear_in_t id;
  int bad_count, cmp_count, cyc, vcnt, tr;
  logic [31:0] seed;
  logic b, p;
  ddrio_gear i_ddrio_gear (.CLK(clk), .RESETN(resetn), .PAD_INPUT_SIGNAL(use_src ? dq : pad_drv),
    .PAD_OUT(pad_out), .PAD_OE(pad_oe), .BYPASS_COMB_INPUT(byp_c), .BYPASS_CLOCK_INPUT(byp_k),
    .IN_CFG(in_cfg), .OUT_CFG(out_cfg), .DYNAMIC_INPUT_DELAY_SEL(dsel), .ISI_DELAY_CTRL(isi),
    .DELAYED_STROBE_CAPTURE_CLOCK(in_cfg.memory_mode & cap_clk),
    .EDGE_CLOCK_ONE(~in_cfg.memory_mode & ~in_cfg.edge_clock_sel & cap_clk),
    .EDGE_CLOCK_TWO(~in_cfg.memory_mode & in_cfg.edge_clock_sel & cap_clk),
    .READ_SYNC_POLARITY(pol), .READ_TRANSFER_LATCH_ENABLE(lat), .WRITE_QUAD_CLOCK_ZERO(qc[2]),
    .WRITE_QUAD_CLOCK_ONE(qc[2] ^ qc[1]), .CORE_CLOCK_ENABLE(ce), .LOCAL_SET_RESET(local_set_reset),
    .GLOBAL_SET_RESET_N(gsr_n), .OUT_DATA(od), .TRISTATE_CONTROL(ts), .IN_DATA(id),
    .CAPTURE_VALID_FLAG(valid));
  ddrio_src i_ddrio_src (.go(go), .bits(bits), .cap_clk(cap_clk), .dq(dq));
  // Free clock at 50 ns.
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // Quadrature write clocks: one step of either every two cycles while enabled.
  always @(posedge clk) begin
    if (qrun) qc <= qc + 3'h1;
  end
  // Valid pulse counter and hang guard.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (valid === 1'b1) vcnt <= vcnt + 1;
    if (cyc == 6000) begin
      bad_count++;
      end_sim();
    end
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk_bit(input string n, input logic e, input logic g);
    cmp_count++;
    if (g !== e) begin
      bad_count++;
      $display("ERROR %s expected %b seen %b", n, e, g);
    end
  endtask
  task automatic chk_in(input string n, input logic [3:0] e, input logic [3:0] g);
    cmp_count++;
    if (g !== e) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic end_sim();
    $display("Comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // Single-rate capture through delay tap d, a lag of d+1 cycles (none with no delay): old value early, new value late.
  task automatic sdr_in(input ddrio_pkg::ddrio_dly_t dm, input logic [3:0] sel, input int d);
    seed = lfsr(seed);
    b = seed[0];
    in_cfg <= {ddrio_pkg::DDRIO_SDR, dm, 2'b00};
    dsel <= sel;
    pad_drv <= ~b;
    wt(30);
    pad_drv <= b;
    wt(1 + d);
    chk_in("sdr old", {3'h0, ~b}, id);
    wt(6);
    chk_in("sdr new", {3'h0, b}, id);
    chk_bit("sdr valid", 1'b1, valid);
    chk_bit("bypass comb", b, byp_c);
    chk_bit("bypass clock", b, byp_k);
  endtask
  // One double-rate burst from the source; sel picks the capture clock route.
  task automatic ddr_in(input ddrio_pkg::ddrio_rate_t m, input logic [1:0] sel, input logic le);
    seed = lfsr(seed);
    bits <= seed[1:0];
    in_cfg <= {m, ddrio_pkg::DDRIO_DLY_NONE, sel};
    lat <= le;
    pol <= seed[2];
    wt(4);
    vcnt = 0;
    go <= 1'b1;
    wt(2);
    go <= 1'b0;
    wt(64);
    chk_bit("ddr valid seen", le, vcnt > 0);
    if (le && m == ddrio_pkg::DDRIO_GEAR) chk_in("gear in", {2{bits[0], bits[1]}}, id);
    else if (le) chk_in("ddr in", {2'b00, bits[0], bits[1]}, {2'b00, id[1:0]});
  endtask
  initial begin
    {resetn, pad_drv, pol, lat, local_set_reset, ts, go, qrun, use_src} = '0;
    {ce, gsr_n} = 2'b11;
    qc = 3'h0;
    dsel = 4'h0;
    isi = 3'h0;
    bits = 2'b00;
    od = 4'h0;
    in_cfg = {ddrio_pkg::DDRIO_SDR, ddrio_pkg::DDRIO_DLY_NONE, 2'b00};
    out_cfg = {ddrio_pkg::DDRIO_SDR, 2'b00};
    {bad_count, cmp_count, cyc, vcnt, tr} = '0;
    seed = 32'h232f;
    wt(20);
    chk_in("reset in", 4'h0, id);
    chk_bit("reset oe", 1'b0, pad_oe);
    resetn <= 1'b1;
    sdr_in(ddrio_pkg::DDRIO_DLY_NONE, 4'h0, 0);
    sdr_in(ddrio_pkg::DDRIO_DLY_FIXED, 4'h0, 3);
    for (int k = 0; k < 4; k++) sdr_in(ddrio_pkg::DDRIO_DLY_DYN, 4'(k * 5), k * 5);
    // Clock enable low holds the captured bit and drops valid.
    ce <= 1'b0;
    pad_drv <= ~pad_drv;
    wt(12);
    chk_bit("ce hold valid", 1'b0, valid);
    chk_in("ce hold data", {3'h0, ~pad_drv}, id);
    ce <= 1'b1;
    wt(12);
    use_src <= 1'b1;
    for (int k = 0; k < 6; k++) ddr_in(k[0] ? ddrio_pkg::DDRIO_GEAR : ddrio_pkg::DDRIO_DDR,
      2'(k >> 1), 1'b1);
    ddr_in(ddrio_pkg::DDRIO_DDR, 2'b00, 1'b0);
    // Local and global set/reset clear the cell.
    for (int k = 0; k < 2; k++) begin
      ts <= 1'b0;
      wt(4);
      if (k == 0) local_set_reset <= 1'b1;
      else gsr_n <= 1'b0;
      wt(1);
      chk_in("set reset in", 4'h0, id);
      chk_bit("set reset oe", 1'b0, pad_oe);
      {local_set_reset, gsr_n} <= 2'b01;
    end
    // Single-rate output in flip-flop and latch form, and the tristate register.
    for (int k = 0; k < 8; k++) begin
      seed = lfsr(seed);
      out_cfg <= {ddrio_pkg::DDRIO_SDR, k[0], 1'b0};
      od <= 4'(seed[3:0]);
      ts <= seed[4];
      wt(4);
      chk_bit("sdr out", seed[0], pad_out);
      chk_bit("sdr oe", ~seed[4], pad_oe);
    end
    // Double-rate output toggles every cycle; interference setting has no effect here.
    out_cfg <= {ddrio_pkg::DDRIO_DDR, 2'b01};
    isi <= 3'h7;
    od <= 4'b0001;
    wt(6);
    for (int k = 0; k < 6; k++) begin
      p = pad_out;
      wt(1);
      chk_bit("ddr out toggle", ~p, pad_out);
    end
    // Gearbox output: alternate bits leave one per write clock step.
    out_cfg <= {ddrio_pkg::DDRIO_GEAR, 2'b00};
    od <= 4'b0101;
    qrun <= 1'b1;
    ts <= 1'b0;
    wt(20);
    chk_bit("gear oe", 1'b1, pad_oe);
    for (int k = 0; k < 16; k++) begin
      p = pad_out;
      wt(1);
      if (p !== pad_out) tr++;
    end
    chk_bit("gear rate", 1'b1, tr >= 7 && tr <= 9);
    od <= 4'hf;
    wt(20);
    chk_bit("gear ones", 1'b1, pad_out);
    // A lone one in 0,0,1,0 is held one extra cycle per word when correction is on.
    for (int k = 0; k < 2; k++) begin
      out_cfg <= {ddrio_pkg::DDRIO_GEAR, 1'b0, k[0]};
      isi <= 3'h1;
      od <= 4'b0100;
      wt(24);
      tr = 0;
      for (int j = 0; j < 16; j++) begin
        wt(1);
        if (pad_out === 1'b1) tr++;
      end
      chk_in("isi ones", k[0] ? 4'h6 : 4'h4, 4'(tr));
    end
    // Stop the write clocks and let their last step drain before the tristate changes.
    qrun <= 1'b0;
    wt(6);
    ts <= 1'b1;
    wt(10);
    chk_bit("gear oe held", 1'b1, pad_oe);
    qrun <= 1'b1;
    wt(10);
    chk_bit("gear oe off", 1'b0, pad_oe);
    end_sim();
  end
endmodule
